//--- fuse_prog_pkg.sv
// Shared constants and state types for the fuse programmer
package fuse_prog_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int WORD_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 12;

  // Tape codes, 7-bit ASCII after the parity channel is dropped
  localparam logic [6:0] CODE_START = 7'h53;
  localparam logic [6:0] CODE_BEGIN = 7'h42;
  localparam logic [6:0] CODE_HIGH = 7'h48;
  localparam logic [6:0] CODE_LOW = 7'h4c;
  localparam logic [6:0] CODE_FINISH = 7'h46;
  localparam logic [6:0] CODE_END = 7'h45;

  localparam logic [2:0] BITS_PER_WORD = 3'h4;
  localparam logic [8:0] WORD_LIMIT = 9'h100;

  // Attempt schedule: three levels, three pulses each
  localparam logic [3:0] MAX_ATTEMPTS = 4'h9;
  localparam logic [3:0] LEVEL0_LAST = 4'h3;
  localparam logic [3:0] LEVEL1_LAST = 4'h6;
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  // Timing in ns at a 25 ns clock
  localparam int CLK_NS = 25;
  localparam int MARGIN_NS = 100;
  localparam int PULSE_NS = 95000;
  localparam int ACCESS_NS = 70;
  localparam int MARGIN_CYC = (MARGIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (MARGIN_NS + ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] MARGIN_LOAD = CNT_W'(MARGIN_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);

  typedef enum logic [1:0] {dsWaitStart, dsBetween, dsInWord, dsEnd} decState_t;
  typedef enum logic [2:0] {
    psIdle, psSettle, psVerify, psSetup, psPulse, psHold, psHalt
  } progState_t;

endpackage

//--- fuse_fifo.sv
// Word FIFO between the tape decoder and the fuse sequencer
`timescale 1ns/1ps
module fuse_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [PTR_W-1:0] wrPtrReg;
  logic [PTR_W-1:0] rdPtrReg;
  logic [CNT_W-1:0] countReg;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = countReg != FULL_COUNT;
  assign outValid = countReg != '0;
  assign outData = memReg[rdPtrReg];

  always_ff @(posedge clk) begin
    if (push) begin
      memReg[wrPtrReg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end else begin
      if (push) begin
        wrPtrReg <= (wrPtrReg == LAST_PTR) ? '0 : wrPtrReg + 1'b1;
      end
      if (pop) begin
        rdPtrReg <= (rdPtrReg == LAST_PTR) ? '0 : rdPtrReg + 1'b1;
      end
      if (push && !pop) begin
        countReg <= countReg + 1'b1;
      end else if (pop && !push) begin
        countReg <= countReg - 1'b1;
      end
    end
  end
endmodule

//--- fuse_programmer.sv
// Tape-fed automatic programmer for a 256 x 4 fuse memory
// Function
// - Address first, then raise enable and output
// - Pulse only one output per attempt
// - Second enable is don't-care; hold it low
// - Verify with both enables low
// - Enable pulse brackets output pulse by 100 ns
// - Verify after every pulse, advance when programmed
// - Nine attempts, three levels of three
// - Decode S, B, H, L, F, E codes
// - Ignore all other characters, state unchanged
// - Tape comments avoid the six code letters
// - Words arrive in order from zero upward
// - Leader of 25 bell or rubout precedes start
// - Channel 1 is MSB, parity ignored
// - Data letters run from output 4 down to 1
// - H is high, L low; address positive logic
`timescale 1ns/1ps
module fuse_programmer
  import fuse_prog_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] tapeChar,
  input wire logic tapeValid,
  output logic tapeReady,
  input wire logic stopOnFail,
  output logic [ADDR_W-1:0] promAddr,
  output logic progEnable,
  output logic enable2,
  output logic [1:0] levelSel,
  input wire logic [DATA_W-1:0] promDataIn,
  output logic [DATA_W-1:0] promDataOut,
  output logic [DATA_W-1:0] promDataOe,
  output logic tapeDone,
  output logic formatErr,
  output logic failFlag,
  output logic failPulse,
  output logic [ADDR_W-1:0] failAddr,
  output logic [1:0] failBit,
  output logic progDone
);

  function automatic logic [1:0] levelOf(input logic [3:0] attempt);
    if (attempt <= LEVEL0_LAST) begin
      return LEVEL_LOW;
    end else if (attempt <= LEVEL1_LAST) begin
      return LEVEL_MID;
    end
    return LEVEL_HIGH;
  endfunction

  // Tape decoder
  decState_t decStateReg;
  logic [DATA_W-1:0] bitsReg;
  logic [2:0] bitCntReg;
  logic [8:0] wordCntReg;
  logic fifoInReady;
  logic fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  logic popReady;

  // Channel 8 is the LSB of tapeChar and never looked at
  wire [6:0] code = tapeChar[7:1];
  wire isStart = code == CODE_START;
  wire isBegin = code == CODE_BEGIN;
  wire isHigh = code == CODE_HIGH;
  wire isLow = code == CODE_LOW;
  wire isFinish = code == CODE_FINISH;
  wire isEnd = code == CODE_END;
  wire isKnown = isStart || isBegin || isHigh || isLow || isFinish || isEnd;
  wire inWord = decStateReg == dsInWord;
  // Stall only a finish code that has nowhere to go
  assign tapeReady = !(inWord && isFinish && !fifoInReady);
  wire take = tapeValid && tapeReady;
  wire wordOk = bitCntReg == BITS_PER_WORD && wordCntReg != WORD_LIMIT;
  wire pushValid = take && inWord && isFinish && wordOk;
  wire [WORD_W-1:0] pushData = {wordCntReg[ADDR_W-1:0], bitsReg};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      decStateReg <= dsWaitStart;
      bitsReg <= '0;
      bitCntReg <= '0;
      wordCntReg <= '0;
      formatErr <= 1'b0;
    end else if (take && isKnown) begin
      unique case (decStateReg)
        dsWaitStart: begin
          if (isStart) begin
            decStateReg <= dsBetween;
          end
        end
        dsBetween: begin
          if (isBegin) begin
            decStateReg <= dsInWord;
            bitCntReg <= '0;
          end else if (isEnd) begin
            decStateReg <= dsEnd;
          end else if (!isStart) begin
            formatErr <= 1'b1;
          end
        end
        dsInWord: begin
          if (isHigh || isLow) begin
            bitsReg <= {bitsReg[DATA_W-2:0], isHigh};
            if (bitCntReg != BITS_PER_WORD) begin
              bitCntReg <= bitCntReg + 1'b1;
            end else begin
              formatErr <= 1'b1;
            end
          end else if (isFinish) begin
            decStateReg <= dsBetween;
            if (wordOk) begin
              wordCntReg <= wordCntReg + 1'b1;
            end else begin
              formatErr <= 1'b1;
            end
          end else if (isBegin) begin
            bitCntReg <= '0;
            formatErr <= 1'b1;
          end else if (isEnd) begin
            decStateReg <= dsEnd;
            formatErr <= 1'b1;
          end
        end
        dsEnd: begin
        end
      endcase
    end
  end
  assign tapeDone = decStateReg == dsEnd;

  fuse_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) wordFifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(fifoOutValid),
    .outReady(popReady),
    .outData(fifoOutData)
  );

  // Fuse sequencer
  progState_t pStateReg;
  progState_t pStateNext;
  logic [CNT_W-1:0] timerReg;
  logic [CNT_W-1:0] timerNext;
  logic [3:0] attemptReg;
  logic [3:0] attemptNext;
  logic [1:0] bitIdxReg;
  logic [1:0] bitIdxNext;
  logic [DATA_W-1:0] wantReg;
  logic failNext;

  assign popReady = pStateReg == psIdle;
  wire timerDone = timerReg == '0;
  // Low reading means the fuse is open
  wire readLow = !promDataIn[bitIdxReg];
  wire wantLow = !wantReg[bitIdxReg];
  wire bitGood = readLow == wantLow;
  wire outOfTries = attemptReg == MAX_ATTEMPTS;
  wire lastBit = bitIdxReg == 2'h0;
  wire driveEnable = pStateNext == psSetup || pStateNext == psPulse || pStateNext == psHold;
  wire [DATA_W-1:0] oneBit = DATA_W'(1) << bitIdxNext;

  always_comb begin
    pStateNext = pStateReg;
    timerNext = timerDone ? '0 : timerReg - 1'b1;
    attemptNext = attemptReg;
    bitIdxNext = bitIdxReg;
    failNext = 1'b0;
    unique case (pStateReg)
      psIdle: begin
        if (fifoOutValid) begin
          // Check first so already-open fuses are never pulsed
          pStateNext = psSettle;
          timerNext = SETTLE_LOAD;
          attemptNext = '0;
          bitIdxNext = 2'h3;
        end
      end
      psSettle: begin
        if (timerDone) begin
          pStateNext = psVerify;
        end
      end
      psVerify: begin
        if (bitGood) begin
          pStateNext = lastBit ? psIdle : psSettle;
        end else if (!wantLow || outOfTries) begin
          failNext = 1'b1;
          pStateNext = stopOnFail ? psHalt : (lastBit ? psIdle : psSettle);
        end else begin
          pStateNext = psSetup;
          attemptNext = attemptReg + 1'b1;
        end
        if (pStateNext == psSettle) begin
          bitIdxNext = bitIdxReg - 1'b1;
          attemptNext = '0;
        end
        timerNext = (pStateNext == psSetup) ? MARGIN_LOAD : SETTLE_LOAD;
      end
      psSetup: begin
        if (timerDone) begin
          pStateNext = psPulse;
          timerNext = PULSE_LOAD;
        end
      end
      psPulse: begin
        if (timerDone) begin
          pStateNext = psHold;
          timerNext = MARGIN_LOAD;
        end
      end
      psHold: begin
        if (timerDone) begin
          pStateNext = psSettle;
          timerNext = SETTLE_LOAD;
        end
      end
      psHalt: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pStateReg <= psIdle;
      timerReg <= '0;
      attemptReg <= '0;
      bitIdxReg <= '0;
    end else begin
      pStateReg <= pStateNext;
      timerReg <= timerNext;
      attemptReg <= attemptNext;
      bitIdxReg <= bitIdxNext;
    end
  end

  // Pin drivers, registered from the next state; promAddr is loaded from the FIFO word on the pop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      promAddr <= '0;
      wantReg <= '1;
      progEnable <= 1'b0;
      levelSel <= LEVEL_LOW;
      promDataOut <= '0;
      promDataOe <= '0;
    end else begin
      if (popReady && fifoOutValid) begin
        promAddr <= fifoOutData[WORD_W-1:DATA_W];
        wantReg <= fifoOutData[DATA_W-1:0];
      end
      progEnable <= driveEnable;
      levelSel <= levelOf(attemptNext);
      promDataOe <= (pStateNext == psPulse) ? oneBit : '0;
      promDataOut <= (pStateNext == psPulse) ? oneBit : '0;
    end
  end
  assign enable2 = 1'b0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      failFlag <= 1'b0;
      failPulse <= 1'b0;
      failAddr <= '0;
      failBit <= '0;
      progDone <= 1'b0;
    end else begin
      failPulse <= failNext;
      if (failNext) begin
        failFlag <= 1'b1;
        failAddr <= promAddr;
        failBit <= bitIdxReg;
      end
      progDone <= tapeDone && !fifoOutValid && pStateNext == psIdle && pStateReg == psIdle;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  wire anyOe = |promDataOe;
  sequence enableLead_s;
    progEnable [*4];
  endsequence
  sequence enableTail_s;
    progEnable [*4] ##1 !progEnable;
  endsequence

  one_output_a: assert property ($onehot0(promDataOe))
    else $error("more than one output pulsed");
  enable2_low_a: assert property (!enable2)
    else $error("second enable not held low");
  verify_enables_a: assert property (pStateReg == psVerify |-> !progEnable && !anyOe)
    else $error("verify without both enables low");
  lead_margin_a: assert property ($rose(anyOe) |-> $past(progEnable, 4) && $past(progEnable))
    else $error("enable did not lead output pulse");
  tail_margin_a: assert property ($fell(anyOe) |-> enableTail_s)
    else $error("enable did not trail output pulse");
  lead_seq_a: assert property ($rose(progEnable) |-> enableLead_s ##1 anyOe)
    else $error("output pulse not after enable setup");
  attempt_cap_a: assert property (attemptReg <= MAX_ATTEMPTS)
    else $error("too many attempts");
  level_group_a: assert property ($rose(anyOe) && attemptReg > LEVEL1_LAST
    |-> levelSel == LEVEL_HIGH)
    else $error("wrong level for late pulse");
  fail_cause_a: assert property ($rose(failPulse) |-> $past(pStateReg) == psVerify
    && ($past(outOfTries) || !$past(wantLow)))
    else $error("fail flagged before ninth attempt");
  pulse_after_check_a: assert property ($rose(progEnable) |-> $past(pStateReg) == psVerify)
    else $error("pulse not preceded by verify");
  ignore_char_a: assert property (take && !isKnown
    |=> $stable(decStateReg) && $stable(bitsReg))
    else $error("unknown character changed decoder");
  end_code_a: assert property (take && isEnd && decStateReg == dsBetween |=> tapeDone)
    else $error("end code not taken");
  word_order_a: assert property (pushValid |=> wordCntReg == $past(wordCntReg) + 9'h1)
    else $error("word address did not advance");
  msb_first_a: assert property (take && inWord && isHigh |=> bitsReg[0])
    else $error("high letter not shifted in");

endmodule

//--- fuse_prom_model.sv
// Behavioural 256 x 4 fuse memory driven by the programmer
`timescale 1ns/1ps
module fuse_prom_model #(
  parameter logic [7:0] SLOW_ADDR = 8'h02,
  parameter logic [1:0] SLOW_BIT = 2'h2,
  parameter int SLOW_NEED = 5,
  parameter logic [7:0] DEAD_ADDR = 8'h03,
  parameter logic [1:0] DEAD_BIT = 2'h0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic newPart,
  input wire logic [7:0] promAddr,
  input wire logic progEnable,
  input wire logic enable2,
  input wire logic [1:0] levelSel,
  input wire logic [3:0] promDataOut,
  input wire logic [3:0] promDataOe,
  output logic [3:0] promDataIn
);
  logic [3:0] mem [256];
  int errCount = 0;
  int lvlCnt [3] = '{0, 0, 0};
  int cyc = 0;
  int peRise = 0;
  int oeFall = 0;
  int slowCnt = 0;
  int stable = 0;
  logic blow;
  logic [7:0] addrPrev = 8'h00;
  logic [3:0] pinPrev = 4'h0;
  logic pePrev = 1'b0;
  wire [3:0] pins = promDataOe & promDataOut;
  wire [1:0] pinIdx = pinPrev[3] ? 2'h3 : pinPrev[2] ? 2'h2 : pinPrev[1] ? 2'h1 : 2'h0;
  // Unsettled reads return the inverse, so an early sample cannot pass
  assign promDataIn = (stable >= 2) ? mem[promAddr] : ~mem[promAddr];
  always @(posedge clk) begin
    cyc++;
    if (newPart) begin
      foreach (mem[i]) mem[i] <= 4'hf;
    end
    stable <= (promAddr == addrPrev && !progEnable && !enable2 && pins == 4'h0) ? stable + 1 : 0;
    if (nrst) begin
      if (enable2 !== 1'b0) errCount++;
      if (progEnable && pePrev && promAddr != addrPrev) errCount++;
      if (progEnable && !pePrev) peRise = cyc;
      if ($countones(pins) > 1) errCount++;
      if (pins != 4'h0 && pinPrev == 4'h0) begin
        lvlCnt[levelSel]++;
        if (cyc - peRise < 4 || !progEnable) errCount++;
      end
      if (pins == 4'h0 && pinPrev != 4'h0) begin
        oeFall = cyc;
        blow = progEnable && !(promAddr == DEAD_ADDR && pinIdx == DEAD_BIT);
        if (promAddr == SLOW_ADDR && pinIdx == SLOW_BIT) begin
          slowCnt++;
          blow = blow && slowCnt >= SLOW_NEED;
        end
        if (blow) mem[promAddr][pinIdx] <= 1'b0;
      end
      if (!progEnable && pePrev && cyc - oeFall < 4) errCount++;
    end
    addrPrev = promAddr;
    pinPrev = pins;
    pePrev = progEnable;
  end
endmodule

//--- fuse_programmer_bench.sv
// Self-checking bench for the tape-fed fuse programmer
`timescale 1ns/1ps
module fuse_programmer_bench
  import fuse_prog_pkg::*;
;
  logic clk, nrst, tapeValid, tapeReady, stopOnFail, newPart, progEnable, enable2;
  logic tapeDone, formatErr, failFlag, failPulse, progDone, par = 1'b0;
  logic [7:0] tapeChar, promAddr, failAddr;
  logic [1:0] levelSel, failBit;
  logic [3:0] promDataIn, promDataOut, promDataOe;
  int nFail = 0;
  int totalChecks = 0;
  int failSeen = 0;
  logic [3:0] wantS1 [4] = '{4'hf, 4'h6, 4'hb, 4'he};
  logic [3:0] memS1 [5] = '{4'hf, 4'h6, 4'hb, 4'hf, 4'hf};

  fuse_programmer dut (.clk(clk), .nrst(nrst), .tapeChar(tapeChar), .tapeValid(tapeValid),
    .tapeReady(tapeReady), .stopOnFail(stopOnFail), .promAddr(promAddr),
    .progEnable(progEnable), .enable2(enable2), .levelSel(levelSel), .promDataIn(promDataIn),
    .promDataOut(promDataOut), .promDataOe(promDataOe), .tapeDone(tapeDone),
    .formatErr(formatErr), .failFlag(failFlag), .failPulse(failPulse), .failAddr(failAddr),
    .failBit(failBit), .progDone(progDone));
  fuse_prom_model partner (.clk(clk), .nrst(nrst), .newPart(newPart), .promAddr(promAddr),
    .progEnable(progEnable), .enable2(enable2), .levelSel(levelSel),
    .promDataOut(promDataOut), .promDataOe(promDataOe), .promDataIn(promDataIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (failPulse === 1'b1) failSeen++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stopTest;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic resetDut(input logic fresh, input logic stop);
    @(posedge clk);
    nrst <= 1'b0;
    tapeValid <= 1'b0;
    newPart <= fresh;
    stopOnFail <= stop;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    newPart <= 1'b0;
    @(posedge clk);
  endtask

  // Parity alternates so a decoder that looks at it gets every word wrong
  task automatic sendChar(input logic [6:0] a);
    logic r;
    par = ~par;
    tapeChar <= {a, par};
    tapeValid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      r = tapeReady;
      @(posedge clk);
      if (r) return;
    end
    nFail++;
    stopTest();
  endtask

  task automatic sendWord(input logic [3:0] d);
    sendChar(CODE_BEGIN);
    for (int b = 3; b >= 0; b--) sendChar(d[b] ? CODE_HIGH : CODE_LOW);
    sendChar(CODE_FINISH);
    sendChar(7'h20);
  endtask

  task automatic waitDone(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (progDone === 1'b1) return;
    end
    nFail++;
    stopTest();
  endtask

  task automatic progFull;
    resetDut(1'b1, 1'b0);
    sendChar(CODE_BEGIN);
    sendChar(CODE_END);
    for (int i = 0; i < 25; i++) sendChar(i[0] ? 7'h7f : 7'h07);
    sendChar(CODE_START);
    sendChar(7'h0d);
    sendChar(7'h0a);
    foreach (wantS1[i]) sendWord(wantS1[i]);
    sendChar(CODE_END);
    tapeValid <= 1'b0;
    repeat (2) @(negedge clk);
    check("tapeDone", tapeDone, 1);
    waitDone(70000);
    foreach (memS1[i]) check("cell", partner.mem[i], memS1[i]);
    check("lvl0", partner.lvlCnt[0], 8);
    check("lvl1", partner.lvlCnt[1], 5);
    check("lvl2", partner.lvlCnt[2], 3);
    check("failFlag", failFlag, 1);
    check("failAddr", failAddr, 3);
    check("failBit", failBit, 0);
    check("failSeen", failSeen, 1);
    check("formatErr", formatErr, 0);
    check("enable2", enable2, 0);
    check("pinErr", partner.errCount, 0);
  endtask

  // Part already programmed: a cell low where high is wanted cannot be fixed
  task automatic haltOnFalse;
    resetDut(1'b0, 1'b1);
    failSeen = 0;
    sendChar(CODE_START);
    sendWord(4'hf);
    sendWord(4'hf);
    sendWord(4'hf);
    sendChar(CODE_END);
    tapeValid <= 1'b0;
    repeat (300) @(negedge clk);
    check("haltFlag", failFlag, 1);
    check("haltAddr", failAddr, 1);
    check("haltBit", failBit, 3);
    check("haltSeen", failSeen, 1);
    check("haltDone", progDone, 0);
    check("noPulse", partner.lvlCnt[0] + partner.lvlCnt[1] + partner.lvlCnt[2], 16);
  endtask

  task automatic fifoFill;
    resetDut(1'b1, 1'b0);
    sendChar(CODE_START);
    sendChar(CODE_BEGIN);
    sendChar(CODE_HIGH);
    sendChar(CODE_FINISH);
    for (int i = 0; i < 17; i++) sendWord(4'h0);
    sendChar(CODE_BEGIN);
    for (int i = 0; i < 4; i++) sendChar(CODE_LOW);
    par = ~par;
    tapeChar <= {CODE_FINISH, par};
    @(negedge clk);
    check("fullStall", tapeReady, 0);
    check("formatErr", formatErr, 1);
    @(posedge clk);
    tapeValid <= 1'b0;
    repeat (2) @(negedge clk);
    check("busyDone", progDone, 0);
    check("pinErr2", partner.errCount, 0);
    resetDut(1'b0, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    tapeChar = 8'h00;
    tapeValid = 1'b0;
    stopOnFail = 1'b0;
    newPart = 1'b0;
    progFull();
    haltOnFalse();
    fifoFill();
    stopTest();
  end
endmodule
